// >>> shared/rsc_pkg.sv
// Purpose: Shared constants and types for the return stack op executor.
// Assumes: 16-bit opcodes, 21-bit program counter, four Q phases a cycle.
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
`default_nettype none
package rsc_pkg;

  // Opcode patterns.
  localparam logic [15:0] OP_PUSH = 16'h0005;
  localparam logic [15:0] OP_POP = 16'h0006;
  localparam logic [15:0] OP_SWRESET = 16'h00ff;
  localparam logic [14:0] OP_IRET = 15'h0008;
  localparam logic [7:0] OP_LITRET = 8'h0c;
  localparam logic [4:0] OP_RELATIVE_SUBROUTINE_CALL = 5'h1b;

  // Timing: four Q phases per instruction cycle, Q1 is phase zero.
  localparam int Q_PER_CYCLE = 4;
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ACCUM = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_BANK = 8'h0c;
  localparam logic [7:0] ADDR_ACC_SH = 8'h10;
  localparam logic [7:0] ADDR_FLG_SH = 8'h14;
  localparam logic [7:0] ADDR_BNK_SH = 8'h18;
  localparam logic [7:0] ADDR_PC_HIGH_LATCH = 8'h1c;
  localparam logic [7:0] ADDR_PC_UPPER_LATCH = 8'h20;
  localparam logic [7:0] ADDR_TOP = 8'h24;
  localparam logic [7:0] ADDR_STKSTAT = 8'h28;

  // Control field positions.
  localparam int CTRL_PRIO_EN_BIT = 0;
  localparam int CTRL_HIGH_EN_BIT = 1;
  localparam int CTRL_LOW_EN_BIT = 2;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_CTRL = 3'h0;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Program counter load request towards the fetch path.
  typedef struct packed {
    logic valid;
    logic [20:0] addr;
  } rsc_pcload_t;

endpackage
`default_nettype wire

// >>> hdl/rsc_core.sv
// Purpose: Executes push, pop, relative call, software reset, interrupt
//   return and literal return against a flip-flop return stack.
// Assumes: The fetch path presents the opcode and its PC during Q1.
// Notes: Registers are reachable over AXI4-Lite; one clock, sync reset.
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rsc_core #(
  parameter int PCW = 21,
  parameter int DEPTH = 31
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [PCW-1:0] pc_i,
  output rsc_pkg::rsc_pcload_t pc_load_o,
  output logic stall_o,
  output logic soft_reset_o,
  output logic [1:0] q_phase_o,
  output logic [7:0] accum_o,
  output logic [7:0] flags_o,
  output logic [7:0] bank_select_o,
  output logic high_priority_global_enable_o,
  output logic low_priority_global_enable_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int SPW = $clog2(DEPTH + 1);
  localparam logic [SPW-1:0] SP_FULL = SPW'(DEPTH);

  // Next sequential instruction address.
  function automatic logic [PCW-1:0] pc_plus2(input logic [PCW-1:0] pc);
    pc_plus2 = pc + PCW'(2);
  endfunction

  // Instruction phase state and captured opcode.
  typedef enum logic [0:0] {RSC_EXEC, RSC_IDLE2} rsc_state_t;
  rsc_state_t state;
  logic [1:0] q;
  logic [15:0] ir;
  logic ir_live;
  logic [PCW-1:0] pc_base;

  // Working, shadow and latch registers.
  logic [7:0] accum, flags, bank, acc_sh, flg_sh, bnk_sh, pc_high_latch, pc_upper_latch;
  logic [2:0] ctrl;
  logic [PCW-1:0] stk [DEPTH];
  logic [SPW-1:0] sp;
  logic ovf, unf;

  // Decode of the captured opcode.
  wire is_push = ir_live && ir == rsc_pkg::OP_PUSH;
  wire is_pop = ir_live && ir == rsc_pkg::OP_POP;
  wire is_swreset = ir_live && ir == rsc_pkg::OP_SWRESET;
  wire is_iret = ir_live && ir[15:1] == rsc_pkg::OP_IRET;
  wire is_litret = ir_live && ir[15:8] == rsc_pkg::OP_LITRET;
  wire is_relative_subroutine_call = ir_live && ir[15:11] == rsc_pkg::OP_RELATIVE_SUBROUTINE_CALL;
  wire two_cycle = is_relative_subroutine_call || is_iret || is_litret;
  wire at_q2 = q == rsc_pkg::Q2;
  wire at_q3 = q == rsc_pkg::Q3;
  wire at_q4 = q == rsc_pkg::Q4;
  wire [PCW-1:0] ret_addr = pc_plus2(pc_base);
  wire [PCW-1:0] rel_off = {{(PCW-12){ir[10]}}, ir[10:0], 1'b0};
  wire [PCW-1:0] call_tgt = ret_addr + rel_off;
  wire [PCW-1:0] top = (sp == '0) ? '0 : stk[sp - SPW'(1)];

  // Stack requests, each in its own Q phase.
  wire do_push = (is_push || is_relative_subroutine_call) && at_q2;
  wire do_pop = (is_pop && at_q3) || ((is_iret || is_litret) && at_q4);
  wire sw_rst = is_swreset && at_q2;
  wire any_rst = rst_i || sw_rst;

  // AXI write address and data holding.
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire wr_lo = wr_fire && w_strb[0];
  wire wr_ctrl = wr_lo && aw_addr == rsc_pkg::ADDR_CTRL;
  wire wr_accum = wr_lo && aw_addr == rsc_pkg::ADDR_ACCUM;
  wire wr_flags = wr_lo && aw_addr == rsc_pkg::ADDR_FLAGS;
  wire wr_bank = wr_lo && aw_addr == rsc_pkg::ADDR_BANK;
  wire wr_accsh = wr_lo && aw_addr == rsc_pkg::ADDR_ACC_SH;
  wire wr_flgsh = wr_lo && aw_addr == rsc_pkg::ADDR_FLG_SH;
  wire wr_bnksh = wr_lo && aw_addr == rsc_pkg::ADDR_BNK_SH;
  wire wr_pc_high_latch = wr_lo && aw_addr == rsc_pkg::ADDR_PC_HIGH_LATCH;
  wire wr_pc_upper_latch = wr_lo && aw_addr == rsc_pkg::ADDR_PC_UPPER_LATCH;
  wire wr_top = wr_fire && aw_addr == rsc_pkg::ADDR_TOP;
  wire aw_mapped = aw_addr <= rsc_pkg::ADDR_STKSTAT && aw_addr[1:0] == 2'h0;

  // Q phase divider and two-cycle sequencing.
  always_ff @(posedge sys_clk_i) begin
    if (any_rst) begin
      q <= rsc_pkg::Q1;
      state <= RSC_EXEC;
    end else begin
      q <= q + 2'h1;
      if (at_q4) begin
        state <= (state == RSC_EXEC && two_cycle) ? RSC_IDLE2 : RSC_EXEC;
      end
    end
  end

  // Opcode capture at the end of Q1; ignored during an idle cycle.
  always_ff @(posedge sys_clk_i) begin
    if (any_rst) begin
      ir <= 16'h0000;
      ir_live <= 1'b0;
      pc_base <= '0;
    end else if (q == rsc_pkg::Q1) begin
      ir <= instr_i;
      ir_live <= instr_valid_i && state == RSC_EXEC;
      pc_base <= pc_i;
    end
  end

  // Return stack storage; a full push drops the value.
  always_ff @(posedge sys_clk_i) begin
    if (do_push && sp != SP_FULL) begin
      stk[sp] <= ret_addr;
    end else if (wr_top && sp != '0) begin
      stk[sp - SPW'(1)] <= w_data[PCW-1:0];
    end
  end

  // Stack pointer moves by one at most per cycle.
  always_ff @(posedge sys_clk_i) begin
    if (any_rst) begin
      sp <= '0;
      ovf <= 1'b0;
      unf <= 1'b0;
    end else begin
      if (do_push) begin
        if (sp == SP_FULL) begin
          ovf <= 1'b1;
        end else begin
          sp <= sp + SPW'(1);
        end
      end
      if (do_pop) begin
        if (sp == '0) begin
          unf <= 1'b1;
        end else begin
          sp <= sp - SPW'(1);
        end
      end
    end
  end

  // Global enables; hardware set wins over a software write.
  always_ff @(posedge sys_clk_i) begin
    if (any_rst) begin
      ctrl <= rsc_pkg::RST_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl <= w_data[2:0];
      end
      if (is_iret && at_q4) begin
        if (ctrl[rsc_pkg::CTRL_PRIO_EN_BIT] &&
            ctrl[rsc_pkg::CTRL_HIGH_EN_BIT]) begin
          ctrl[rsc_pkg::CTRL_LOW_EN_BIT] <= 1'b1;
        end else begin
          ctrl[rsc_pkg::CTRL_HIGH_EN_BIT] <= 1'b1;
        end
      end
    end
  end

  // Working registers; literal and shadow loads happen in Q4.
  always_ff @(posedge sys_clk_i) begin
    if (any_rst) begin
      accum <= rsc_pkg::RST_BYTE;
      flags <= rsc_pkg::RST_BYTE;
      bank <= rsc_pkg::RST_BYTE;
    end else begin
      // Software writes come first, so a hardware load in the same cycle
      // wins only for the register that it actually loads.
      if (wr_accum) accum <= w_data[7:0];
      if (wr_flags) flags <= w_data[7:0];
      if (wr_bank) bank <= w_data[7:0];
      if (at_q4 && is_litret) begin
        accum <= ir[7:0];
      end
      if (at_q4 && is_iret && ir[0]) begin
        accum <= acc_sh;
        flags <= flg_sh;
        bank <= bnk_sh;
      end
    end
  end

  // Shadows and address latches change only by software or reset.
  always_ff @(posedge sys_clk_i) begin
    if (any_rst) begin
      acc_sh <= rsc_pkg::RST_BYTE;
      flg_sh <= rsc_pkg::RST_BYTE;
      bnk_sh <= rsc_pkg::RST_BYTE;
      pc_high_latch <= rsc_pkg::RST_BYTE;
      pc_upper_latch <= rsc_pkg::RST_BYTE;
    end else begin
      if (wr_accsh) acc_sh <= w_data[7:0];
      if (wr_flgsh) flg_sh <= w_data[7:0];
      if (wr_bnksh) bnk_sh <= w_data[7:0];
      if (wr_pc_high_latch) pc_high_latch <= w_data[7:0];
      if (wr_pc_upper_latch) pc_upper_latch <= w_data[7:0];
    end
  end

  // Program counter load to the fetch path and reset pulse.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pc_load_o <= '0;
      soft_reset_o <= 1'b0;
    end else begin
      soft_reset_o <= sw_rst;
      pc_load_o.valid <= 1'b0;
      if (at_q4 && is_relative_subroutine_call) begin
        pc_load_o.valid <= 1'b1;
        pc_load_o.addr <= call_tgt;
      end else if (at_q4 && (is_iret || is_litret)) begin
        pc_load_o.valid <= 1'b1;
        pc_load_o.addr <= top;
      end
    end
  end

  assign stall_o = state == RSC_IDLE2;
  assign q_phase_o = q;
  assign accum_o = accum;
  assign flags_o = flags;
  assign bank_select_o = bank;
  assign high_priority_global_enable_o = ctrl[rsc_pkg::CTRL_HIGH_EN_BIT];
  assign low_priority_global_enable_o = ctrl[rsc_pkg::CTRL_LOW_EN_BIT];

  // AXI write channel: address and data taken in either order.
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rsc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_mapped ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode.
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == rsc_pkg::ADDR_CTRL) begin
      rd_word[2:0] = ctrl;
    end else if (s_axi_araddr == rsc_pkg::ADDR_ACCUM) begin
      rd_word[7:0] = accum;
    end else if (s_axi_araddr == rsc_pkg::ADDR_FLAGS) begin
      rd_word[7:0] = flags;
    end else if (s_axi_araddr == rsc_pkg::ADDR_BANK) begin
      rd_word[7:0] = bank;
    end else if (s_axi_araddr == rsc_pkg::ADDR_ACC_SH) begin
      rd_word[7:0] = acc_sh;
    end else if (s_axi_araddr == rsc_pkg::ADDR_FLG_SH) begin
      rd_word[7:0] = flg_sh;
    end else if (s_axi_araddr == rsc_pkg::ADDR_BNK_SH) begin
      rd_word[7:0] = bnk_sh;
    end else if (s_axi_araddr == rsc_pkg::ADDR_PC_HIGH_LATCH) begin
      rd_word[7:0] = pc_high_latch;
    end else if (s_axi_araddr == rsc_pkg::ADDR_PC_UPPER_LATCH) begin
      rd_word[7:0] = pc_upper_latch;
    end else if (s_axi_araddr == rsc_pkg::ADDR_TOP) begin
      rd_word[PCW-1:0] = top;
    end else if (s_axi_araddr == rsc_pkg::ADDR_STKSTAT) begin
      rd_word[SPW-1:0] = sp;
      rd_word[16] = ovf;
      rd_word[17] = unf;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // AXI read channel: one cycle from address to data.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rsc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  a_push_top_value: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_push && at_q2 && sp != SP_FULL |=> top == pc_plus2(pc_base))
    else $error("Push did not store PC plus two on top.");

  a_push_depth_grows: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    do_push && !do_pop && !wr_flags && sp != SP_FULL |=>
      sp == $past(sp) + SPW'(1)
      && $stable(flags))
    else $error("Push did not deepen the stack by one.");

  a_relative_subroutine_call_target_addr: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_relative_subroutine_call && at_q4 |=> pc_load_o.valid &&
      pc_load_o.addr == $past(ret_addr) + $past(rel_off))
    else $error("Relative call target address is wrong.");

  a_two_cycle_idle: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    two_cycle && at_q4 && state == RSC_EXEC |=> stall_o [*4] ##1 !stall_o)
    else $error("Second cycle was not exactly one idle cycle.");

  a_swreset_at_q2: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    soft_reset_o |-> $past(q) == rsc_pkg::Q2 && q == rsc_pkg::Q1 && sp == '0)
    else $error("Software reset pulse out of phase.");

  a_iret_enable_set: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_iret && at_q4 |=> high_priority_global_enable_o ||
      low_priority_global_enable_o)
    else $error("Interrupt return left enables clear.");

  a_iret_restore: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_iret && at_q4 && ir[0] |=> accum == $past(acc_sh) &&
      flags == $past(flg_sh) && bank == $past(bnk_sh))
    else $error("Shadow restore did not happen.");

  a_litret_accum: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    is_litret && at_q4 |=> accum == $past(ir[7:0]) &&
      pc_load_o.addr == $past(top))
    else $error("Literal return loaded wrong values.");

  a_latch_kept: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (is_litret || is_iret) && at_q4 && !wr_pc_high_latch && !wr_pc_upper_latch |=>
      $stable(pc_high_latch) && $stable(pc_upper_latch))
    else $error("Return changed the PC high latch.");

  a_pop_depth_drops: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    do_pop && !do_push && sp != '0 |=> sp == $past(sp) - SPW'(1))
    else $error("Pop did not remove the top entry.");

endmodule // rsc_core
`default_nettype wire

// >>> tb/tb_rsc_core.sv
// Purpose: Self-checking bench for the return stack op executor.
// Assumes: Opcodes go in at Q1; registers are read over AXI4-Lite.
// Notes: Each op is watched for a fixed window of 14 clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_rsc_core;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [20:0] pc_i = 21'h000000;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  rsc_pkg::rsc_pcload_t pc_load_o;
  logic stall_o, soft_reset_o, hi_en, lo_en;
  logic [1:0] q_phase_o, s_axi_bresp, s_axi_rresp;
  logic [7:0] accum_o, flags_o, bank_select_o;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata, rdat;
  logic [1:0] rrsp, wrsp;
  logic [20:0] ld;
  int fails = 0;
  int n_compared = 0;
  int nl, ns, nr;
  int cyc = 0;

  rsc_core rsc_core_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .pc_i(pc_i), .pc_load_o(pc_load_o),
    .stall_o(stall_o), .soft_reset_o(soft_reset_o), .q_phase_o(q_phase_o),
    .accum_o(accum_o), .flags_o(flags_o), .bank_select_o(bank_select_o),
    .high_priority_global_enable_o(hi_en),
    .low_priority_global_enable_o(lo_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  // Free-running 100 MHz clock.
  always #5 sys_clk_i = ~sys_clk_i;

  // Cuts a hang short well past the expected run length.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Writes one word; ready is looked at 1 ns after an edge, when it is
  // settled for the coming edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic awt, wt, bt;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      #1;
      awt = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      bt = s_axi_bvalid;
      wrsp = s_axi_bresp;
      @(posedge sys_clk_i);
      if (awt) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
      if (bt) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  // Reads one word into rdat and rrsp.
  task automatic axi_rd(input logic [7:0] a);
    logic art, rt;
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      #1;
      art = s_axi_arvalid && s_axi_arready;
      rt = s_axi_rvalid;
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      @(posedge sys_clk_i);
      if (art) s_axi_arvalid <= 1'b0;
      if (rt) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // Reads a register and expects an OKAY answer with the given data.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    chk({30'h0, rrsp}, {30'h0, rsc_pkg::RESP_OKAY});
    chk(rdat, e);
  endtask

  // Offers one opcode at Q1, then counts loads, stall and reset pulses.
  task automatic exec(input logic [15:0] op, input logic [20:0] pc);
    do begin
      @(posedge sys_clk_i);
      #1;
    end while (q_phase_o !== rsc_pkg::Q4 || stall_o !== 1'b0);
    @(posedge sys_clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= op;
    pc_i <= pc;
    @(posedge sys_clk_i);
    instr_valid_i <= 1'b0;
    nl = 0;
    ns = 0;
    nr = 0;
    repeat (14) begin
      #1;
      if (pc_load_o.valid === 1'b1) begin
        nl++;
        ld = pc_load_o.addr;
      end
      if (stall_o === 1'b1) ns++;
      if (soft_reset_o === 1'b1) nr++;
      @(posedge sys_clk_i);
    end
  endtask

  // Calls at two offset limits and plus one, with their targets.
  logic [15:0] c_op [3] = '{16'hd801, 16'hdc00, 16'hdbff};
  logic [20:0] c_pc [3] = '{21'h000100, 21'h001000, 21'h000100};
  logic [20:0] c_to [3] = '{21'h000104, 21'h000802, 21'h000900};

  // Main sequence.
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(rsc_pkg::ADDR_STKSTAT, 32'h0);
    rd(rsc_pkg::ADDR_CTRL, 32'h0);
    axi_wr(rsc_pkg::ADDR_FLAGS, 32'h5a);
    exec(rsc_pkg::OP_PUSH, 21'h000124);
    rd(rsc_pkg::ADDR_TOP, 32'h126);
    exec(rsc_pkg::OP_PUSH, 21'h000200);
    rd(rsc_pkg::ADDR_TOP, 32'h202);
    rd(rsc_pkg::ADDR_STKSTAT, 32'h2);
    chk({24'h0, flags_o}, 32'h5a);
    exec(rsc_pkg::OP_POP, 21'h000202);
    rd(rsc_pkg::ADDR_TOP, 32'h126);
    rd(rsc_pkg::ADDR_STKSTAT, 32'h1);
    for (int i = 0; i < 3; i++) begin
      exec(c_op[i], c_pc[i]);
      chk({11'h0, ld}, {11'h0, c_to[i]});
      chk(ns, 4);
      rd(rsc_pkg::ADDR_TOP, {11'h0, c_pc[i]} + 32'h2);
    end
    axi_wr(rsc_pkg::ADDR_PC_HIGH_LATCH, 32'h37);
    axi_wr(rsc_pkg::ADDR_PC_UPPER_LATCH, 32'h05);
    exec(16'h0c9a, 21'h000900);
    chk({11'h0, ld}, 32'h102);
    chk({24'h0, accum_o}, 32'h9a);
    chk(ns, 4);
    rd(rsc_pkg::ADDR_PC_HIGH_LATCH, 32'h37);
    rd(rsc_pkg::ADDR_STKSTAT, 32'h3);
    axi_wr(rsc_pkg::ADDR_ACC_SH, 32'h11);
    axi_wr(rsc_pkg::ADDR_FLG_SH, 32'h22);
    axi_wr(rsc_pkg::ADDR_BNK_SH, 32'h33);
    exec(16'h0010, 21'h000102);
    chk({11'h0, ld}, 32'h1002);
    chk({31'h0, hi_en}, 32'h1);
    chk({16'h0, accum_o, flags_o}, 32'h9a5a);
    chk(nl + ns, 5);
    axi_wr(rsc_pkg::ADDR_CTRL, 32'h3);
    exec(16'h0011, 21'h001002);
    chk({11'h0, ld}, 32'h102);
    chk({31'h0, lo_en}, 32'h1);
    chk({8'h0, accum_o, flags_o, bank_select_o}, 32'h112233);
    rd(rsc_pkg::ADDR_PC_UPPER_LATCH, 32'h05);
    rd(rsc_pkg::ADDR_PC_HIGH_LATCH, 32'h37);
    exec(rsc_pkg::OP_SWRESET, 21'h000102);
    chk(nr, 1);
    chk({24'h0, accum_o}, 32'h0);
    rd(rsc_pkg::ADDR_CTRL, 32'h0);
    rd(rsc_pkg::ADDR_STKSTAT, 32'h0);
    exec(rsc_pkg::OP_POP, 21'h000000);
    rd(rsc_pkg::ADDR_STKSTAT, 32'h20000);
    rd(rsc_pkg::ADDR_TOP, 32'h0);
    // Fill the 31-entry stack and push once more: overflow is sticky.
    for (int k = 0; k < 32; k++) begin
      exec(rsc_pkg::OP_PUSH, 21'h000300);
    end
    rd(rsc_pkg::ADDR_STKSTAT, 32'h3001f);
    rd(rsc_pkg::ADDR_TOP, 32'h302);
    axi_wr(8'h40, 32'h1);
    chk({30'h0, wrsp}, {30'h0, rsc_pkg::RESP_SLVERR});
    axi_rd(8'h40);
    chk({30'h0, rrsp}, {30'h0, rsc_pkg::RESP_SLVERR});
    report_and_stop();
  end
endmodule // tb_rsc_core
`default_nettype wire
